// *** core/bpd_pkg.sv ***
package bpd_pkg;

    // ********************************
    // Diagnostic word layout
    // ********************************
    localparam int DIAG_W   = 64;
    localparam int USED_W   = 28;
    localparam int INSTRUCTION_XLATE_BUFFER_LSB = 0;
    localparam int INSTRUCTION_XLATE_BUFFER_W   = 4;
    localparam int BSEL_LSB = 4;
    localparam int BSEL_W   = 4;
    localparam int RCD_BIT  = 8;
    localparam int RCV_BIT  = 9;
    localparam int RCW_BIT  = 10;
    localparam int RCH_BIT  = 11;
    localparam int MISP_BIT = 12;
    localparam int ALG_LSB  = 13;
    localparam int PST_LSB  = 15;
    localparam int IDX_LSB  = 17;
    localparam int IDX_W    = 9;
    localparam int LINE_LSB = 3;
    localparam int OP_LSB   = 26;

    // ********************************
    // Reset values and line fill patterns
    // ********************************
    localparam logic [INSTRUCTION_XLATE_BUFFER_W-1:0] INSTRUCTION_XLATE_BUFFER_RESET = 4'h0;
    localparam logic [BSEL_W-1:0] BSEL_RESET = 4'h0;
    localparam logic [1:0]        ALG_RESET  = 2'h0;
    localparam logic [1:0]        PST_RESET  = 2'h0;
    localparam logic [IDX_W-1:0]  IDX_RESET  = 9'h000;
    localparam logic [1:0]        LINE_ZERO  = 2'h0;
    localparam logic [1:0]        LINE_ONES  = 2'h3;

    // ********************************
    // Encodings
    // ********************************
    typedef enum logic [1:0] {
        BPD_ALG_COUNTER   = 2'b00,
        BPD_ALG_NOT_TAKEN = 2'b01,
        BPD_ALG_TAKEN     = 2'b10,
        BPD_ALG_BTFN      = 2'b11
    } bpd_alg_e;

    typedef enum logic [1:0] {
        BPD_OP_READ       = 2'b00,
        BPD_OP_WRITE      = 2'b01,
        BPD_OP_CLEAR_LINE = 2'b10,
        BPD_OP_SET_LINE   = 2'b11
    } bpd_op_e;

    typedef enum logic {
        BPD_PH_IDLE = 1'b0,
        BPD_PH_WAIT = 1'b1
    } bpd_phase_e;

    // ********************************
    // Carriers
    // ********************************
    typedef struct packed {
        bpd_op_e          op;
        logic [IDX_W-1:0] index;
        logic [1:0]       wdata;
    } bpd_tbl_req_s;

    typedef struct packed {
        logic       instruction_xlate_buffer_miss;
        logic       link_branch;
        logic       link_wrote;
        logic       ret_jump;
        logic       ret_hit;
        logic       cond_verify;
        logic       cond_mispredict;
        logic [1:0] cond_state;
    } bpd_br_evt_s;

    typedef struct packed {
        logic [INSTRUCTION_XLATE_BUFFER_W-1:0] instruction_xlate_buffer_cnt;
        logic [BSEL_W-1:0] bsel;
        logic              rc_disable;
        logic              rc_valid;
        logic              rc_written;
        logic              rc_hit;
        logic              mispredict;
        bpd_alg_e          alg;
        logic [1:0]        pstate;
        logic [IDX_W-1:0]  index;
        bpd_op_e           op;
        bpd_phase_e        phase;
    } bpd_state_s;

endpackage

// *** core/bpd_diag.sv ***
`timescale 1ns/10ps

// Functional notes
// - One 64-bit register holds every field
// - Miss counter readable, software writes ignored
// - Miss counter undefined during reset
// - Stack index meaningless after unconditional branch
// - Disable bit stops return cache prediction
// - Valid bit mirrors one-entry return cache
// - Written bit changes only on linking branches
// - Hit bit changes only on return jumps
// - Mispredict bit updated on each verification
// - Mode field selects prediction algorithm
// - Mode resets to counter scheme
// - State field takes verified and table states
// - Line init ignores three low index bits
// - Op field selects read, write, clear, set
// - Reserved bits read zero, written zero
// - Table access yields to instruction fetch
module bpd_diag
    import bpd_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Coprocessor moves
    input  wire logic              mt_en,
    input  wire logic [DIAG_W-1:0] mt_data,
    output logic      [DIAG_W-1:0] diag_rdata,
    // Pipeline events and levels
    input  wire bpd_br_evt_s       br_evt,
    input  wire logic [BSEL_W-1:0] bsel_in,
    input  wire logic              rc_valid_in,
    // Prediction controls
    output logic                   return_cache_disable,
    output bpd_alg_e               predict_algorithm_sel,
    // Prediction table port
    output logic                   tbl_valid,
    output bpd_tbl_req_s           tbl_cmd,
    output logic                   tbl_fire,
    input  wire logic              fetch_busy,
    input  wire logic [1:0]        tbl_rdata
);

    // ********************************
    // State
    // ********************************
    bpd_state_s st;
    bpd_state_s next_st;
    logic       rd_done;

    // Fetch always wins; our request stays valid at the table but fires only in idle slots
    assign tbl_valid = (st.phase == BPD_PH_WAIT);
    assign tbl_fire  = tbl_valid && !fetch_busy;
    assign rd_done   = tbl_fire && (st.op == BPD_OP_READ);

    always_comb begin
        next_st = st;
        // Counter wraps; software has no path into it
        if (br_evt.instruction_xlate_buffer_miss) begin
            next_st.instruction_xlate_buffer_cnt = st.instruction_xlate_buffer_cnt + 4'h1;
        end
        // Branch stack owns this value; stale after unconditional jumps
        next_st.bsel     = bsel_in;
        next_st.rc_valid = rc_valid_in;
        if (br_evt.link_branch) begin
            next_st.rc_written = br_evt.link_wrote;
        end
        if (br_evt.ret_jump) begin
            next_st.rc_hit = br_evt.ret_hit;
        end
        if (br_evt.cond_verify) begin
            next_st.mispredict = br_evt.cond_mispredict;
            next_st.pstate     = br_evt.cond_state;
        end
        if (tbl_fire) begin
            next_st.phase = BPD_PH_IDLE;
        end
        // A new write replaces any operation still waiting
        if (mt_en) begin
            next_st.rc_disable = mt_data[RCD_BIT];
            next_st.alg        = bpd_alg_e'(mt_data[ALG_LSB +: 2]);
            next_st.pstate     = mt_data[PST_LSB +: 2];
            next_st.index      = mt_data[IDX_LSB +: IDX_W];
            next_st.op         = bpd_op_e'(mt_data[OP_LSB +: 2]);
            next_st.phase      = BPD_PH_WAIT;
        end
        // Late read data wins, as software polls for it after the launch
        if (rd_done) begin
            next_st.pstate = tbl_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Counter is cleared too, though its value is not promised
            st.instruction_xlate_buffer_cnt   <= INSTRUCTION_XLATE_BUFFER_RESET;
            st.bsel       <= BSEL_RESET;
            st.rc_disable <= 1'b0;
            st.rc_valid   <= 1'b0;
            st.rc_written <= 1'b0;
            st.rc_hit     <= 1'b0;
            st.mispredict <= 1'b0;
            st.alg        <= bpd_alg_e'(ALG_RESET);
            st.pstate     <= PST_RESET;
            st.index      <= IDX_RESET;
            st.op         <= BPD_OP_READ;
            st.phase      <= BPD_PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign return_cache_disable  = st.rc_disable;
    assign predict_algorithm_sel = st.alg;

    always_comb begin
        tbl_cmd.op    = st.op;
        tbl_cmd.index = st.index;
        tbl_cmd.wdata = st.pstate;
        unique case (st.op)
            BPD_OP_READ,
            BPD_OP_WRITE: begin
                tbl_cmd.wdata = st.pstate;
            end
            BPD_OP_CLEAR_LINE: begin
                tbl_cmd.index = {st.index[IDX_W-1:LINE_LSB], 3'h0};
                tbl_cmd.wdata = LINE_ZERO;
            end
            BPD_OP_SET_LINE: begin
                tbl_cmd.index = {st.index[IDX_W-1:LINE_LSB], 3'h0};
                tbl_cmd.wdata = LINE_ONES;
            end
        endcase
    end

    // Upper bits are tied off so readback of reserved space is zero
    assign diag_rdata = {
        {(DIAG_W-USED_W){1'b0}},
        st.op, st.index, st.pstate, st.alg,
        st.mispredict, st.rc_hit, st.rc_written, st.rc_valid,
        st.rc_disable, st.bsel, st.instruction_xlate_buffer_cnt
    };

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    alg_reset_a: assert property (disable iff (1'b0)
        rst |=> predict_algorithm_sel == BPD_ALG_COUNTER)
        else $error("mode not counter after reset");

    instruction_xlate_buffer_ro_a: assert property (
        mt_en && !br_evt.instruction_xlate_buffer_miss |=> $stable(diag_rdata[INSTRUCTION_XLATE_BUFFER_LSB +: INSTRUCTION_XLATE_BUFFER_W]))
        else $error("miss counter changed by write");

    instruction_xlate_buffer_inc_a: assert property (
        br_evt.instruction_xlate_buffer_miss |=>
        diag_rdata[INSTRUCTION_XLATE_BUFFER_LSB +: INSTRUCTION_XLATE_BUFFER_W] == $past(diag_rdata[INSTRUCTION_XLATE_BUFFER_LSB +: INSTRUCTION_XLATE_BUFFER_W]) + 4'h1)
        else $error("miss counter did not step");

    rsv_zero_a: assert property (
        diag_rdata[DIAG_W-1:USED_W] == '0)
        else $error("reserved bits nonzero");

    rcw_hold_a: assert property (
        !br_evt.link_branch |=> $stable(diag_rdata[RCW_BIT]))
        else $error("written bit moved without link");

    rch_track_a: assert property (
        br_evt.ret_jump |=> diag_rdata[RCH_BIT] == $past(br_evt.ret_hit))
        else $error("hit bit wrong");

    misp_track_a: assert property (
        br_evt.cond_verify |=> diag_rdata[MISP_BIT] == $past(br_evt.cond_mispredict))
        else $error("mispredict bit wrong");

    rcd_write_a: assert property (
        mt_en |=> return_cache_disable == $past(mt_data[RCD_BIT]))
        else $error("disable bit not written");

    launch_a: assert property (
        mt_en |=> tbl_valid ##0 tbl_cmd.op == $past(mt_data[OP_LSB +: 2]))
        else $error("write did not launch op");

    once_a: assert property (
        tbl_fire && !mt_en |=> !tbl_valid ##1 (!tbl_valid || $past(mt_en)))
        else $error("operation launched twice");

    fetch_prio_a: assert property (
        fetch_busy |-> !tbl_fire)
        else $error("table used during fetch");

    line_idx_a: assert property (
        tbl_valid && tbl_cmd.op[1] |-> tbl_cmd.index[LINE_LSB-1:0] == 3'h0)
        else $error("line index low bits set");

    rd_back_a: assert property (
        rd_done && !mt_en |=> diag_rdata[PST_LSB +: 2] == $past(tbl_rdata))
        else $error("read result not returned");

    instruction_xlate_buffer_hold_a: assert property (
        !br_evt.instruction_xlate_buffer_miss |=> $stable(diag_rdata[INSTRUCTION_XLATE_BUFFER_LSB +: INSTRUCTION_XLATE_BUFFER_W]))
        else $error("miss counter moved without miss");

    bsel_track_a: assert property (
        1'b1 |=> diag_rdata[BSEL_LSB +: BSEL_W] == $past(bsel_in))
        else $error("stack index not tracked");

    rcd_hold_a: assert property (
        !mt_en |=> $stable(return_cache_disable))
        else $error("disable bit moved without write");

    rcv_track_a: assert property (
        1'b1 |=> diag_rdata[RCV_BIT] == $past(rc_valid_in))
        else $error("valid bit not tracked");

    rcw_write_a: assert property (
        br_evt.link_branch |=> diag_rdata[RCW_BIT] == $past(br_evt.link_wrote))
        else $error("written bit not taken from link");

    rch_hold_a: assert property (
        !br_evt.ret_jump |=> $stable(diag_rdata[RCH_BIT]))
        else $error("hit bit moved without return jump");

    misp_hold_a: assert property (
        !br_evt.cond_verify |=> $stable(diag_rdata[MISP_BIT]))
        else $error("mispredict bit moved without verify");

    alg_write_a: assert property (
        mt_en |=> predict_algorithm_sel == $past(mt_data[ALG_LSB +: 2]))
        else $error("mode not written");

    alg_hold_a: assert property (
        !mt_en |=> $stable(predict_algorithm_sel))
        else $error("mode moved without write");

    rst_clear_a: assert property (disable iff (1'b0)
        rst |=> diag_rdata[DIAG_W-1:INSTRUCTION_XLATE_BUFFER_W] == '0 && !tbl_valid)
        else $error("fields not cleared by reset");

    pst_write_a: assert property (
        mt_en && !rd_done |=> diag_rdata[PST_LSB +: 2] == $past(mt_data[PST_LSB +: 2]))
        else $error("state field not written");

    pst_verify_a: assert property (
        br_evt.cond_verify && !mt_en && !rd_done |=>
        diag_rdata[PST_LSB +: 2] == $past(br_evt.cond_state))
        else $error("verified state not taken");

    pst_hold_a: assert property (
        !br_evt.cond_verify && !mt_en && !rd_done |=> $stable(diag_rdata[PST_LSB +: 2]))
        else $error("state field moved without source");

    idx_write_a: assert property (
        mt_en |=> diag_rdata[IDX_LSB +: IDX_W] == $past(mt_data[IDX_LSB +: IDX_W]))
        else $error("index field not written");

    line_upper_a: assert property (
        tbl_valid && tbl_cmd.op[1] |->
        tbl_cmd.index[IDX_W-1:LINE_LSB] == diag_rdata[IDX_LSB+LINE_LSB +: IDX_W-LINE_LSB])
        else $error("line address wrong");

    op_write_a: assert property (
        mt_en |=> diag_rdata[OP_LSB +: 2] == $past(mt_data[OP_LSB +: 2]))
        else $error("op field not written");

    clear_data_a: assert property (
        tbl_valid && tbl_cmd.op == BPD_OP_CLEAR_LINE |-> tbl_cmd.wdata == LINE_ZERO)
        else $error("clear line data wrong");

    set_data_a: assert property (
        tbl_valid && tbl_cmd.op == BPD_OP_SET_LINE |-> tbl_cmd.wdata == LINE_ONES)
        else $error("set line data wrong");

    fire_free_a: assert property (
        tbl_valid && !fetch_busy |-> tbl_fire)
        else $error("free table slot not used");

    wait_hold_a: assert property (
        tbl_valid && fetch_busy && !mt_en |=>
        tbl_valid && $stable(tbl_cmd.op) && $stable(tbl_cmd.index))
        else $error("waiting request lost or changed");

    entry_cmd_a: assert property (
        tbl_valid && !tbl_cmd.op[1] |->
        tbl_cmd.index == diag_rdata[IDX_LSB +: IDX_W] && tbl_cmd.wdata == diag_rdata[PST_LSB +: 2])
        else $error("entry request does not match fields");

    idle_hold_a: assert property (
        !tbl_valid && !mt_en |=> !tbl_valid)
        else $error("request without write");

    delayed_read_c: cover property (
        mt_en ##1 (tbl_valid && fetch_busy) [*3] ##1 tbl_fire);
    set_line_c: cover property (
        tbl_fire && tbl_cmd.op == BPD_OP_SET_LINE);
    mispredict_c: cover property (
        br_evt.cond_verify && br_evt.cond_mispredict);
    rc_hit_c: cover property (
        br_evt.ret_jump && br_evt.ret_hit && !return_cache_disable);
    clear_line_c: cover property (
        tbl_fire && tbl_cmd.op == BPD_OP_CLEAR_LINE);

endmodule

// *** test/bpd_diag_tb.sv ***
`timescale 1ns/10ps

module bpd_diag_tb
    import bpd_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic                 ref_clk = 1'b0;
    logic                 rst     = 1'b1;
    logic                 mt_en   = 1'b0;
    logic [DIAG_W-1:0]    mt_data = '0;
    logic [DIAG_W-1:0]    diag_rdata;
    bpd_br_evt_s          br_evt  = '0;
    logic [BSEL_W-1:0]    bsel_in = 4'h0;
    logic                 rc_valid_in = 1'b0;
    logic                 return_cache_disable;
    bpd_alg_e             predict_algorithm_sel;
    logic                 tbl_valid;
    bpd_tbl_req_s         tbl_cmd;
    logic                 tbl_fire;
    logic                 fetch_busy = 1'b1;
    logic [1:0]           tbl_rdata  = 2'h0;
    int                   errors = 0;
    int                   samples_checked = 0;
    logic [3:0]           miss0;

    typedef struct packed {
        logic [63:0] wr;
        logic [63:0] rb;
        logic [12:0] cmd;
        logic [1:0]  rd;
        logic [1:0]  pst;
    } bpd_row_s;

    // Index fields carry branch address bits 11:3; junk only in read-only status bits
    bpd_row_s rows [4] = '{
        '{64'h0000_0000_03FE_9FFF, 64'h0000_0000_03FE_8100, 13'h07FD, 2'h2, 2'h2},
        '{64'h0000_0000_054B_A000, 64'h0000_0000_054B_A000, 13'h0A97, 2'h0, 2'h3},
        '{64'h0000_0000_0A5F_4100, 64'h0000_0000_0A5F_4100, 13'h14A0, 2'h1, 2'h2},
        '{64'h0000_0000_0C0E_E000, 64'h0000_0000_0C0E_E000, 13'h1803, 2'h0, 2'h1}
    };

    always #20 ref_clk = ~ref_clk;

    bpd_diag u_bpd_diag (
        .ref_clk               (ref_clk),
        .rst                   (rst),
        .mt_en                 (mt_en),
        .mt_data               (mt_data),
        .diag_rdata            (diag_rdata),
        .br_evt                (br_evt),
        .bsel_in               (bsel_in),
        .rc_valid_in           (rc_valid_in),
        .return_cache_disable  (return_cache_disable),
        .predict_algorithm_sel (predict_algorithm_sel),
        .tbl_valid             (tbl_valid),
        .tbl_cmd               (tbl_cmd),
        .tbl_fire              (tbl_fire),
        .fetch_busy            (fetch_busy),
        .tbl_rdata             (tbl_rdata)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic wr(input logic [63:0] d);
        @(negedge ref_clk) mt_en = 1'b1;
        mt_data = d;
        @(negedge ref_clk) mt_en = 1'b0;
    endtask

    task automatic ev(input bpd_br_evt_s e);
        @(negedge ref_clk) br_evt = e;
        @(negedge ref_clk) br_evt = '0;
    endtask

    task automatic stop_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    // Miss counter is masked until observed, since its reset value is not promised
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        chk("reset word", 64'h0, diag_rdata & ~64'hF);
        chk("reset pending", 64'h0, tbl_valid);
        foreach (rows[i]) begin
            fetch_busy = 1'b1;
            wr(rows[i].wr);
            chk("readback", rows[i].rb, diag_rdata & ~64'hF);
            chk("rc disable", rows[i].rb[8], return_cache_disable);
            chk("mode", rows[i].rb[14:13], predict_algorithm_sel);
            chk("cmd", {1'b1, rows[i].cmd[12:2]}, {tbl_valid, tbl_cmd[12:2]});
            if (rows[i].cmd[12:11] != 2'h0)
                chk("wdata", rows[i].cmd[1:0], tbl_cmd.wdata);
            repeat (2) @(negedge ref_clk);
            chk("stall", 64'h2, {tbl_valid, tbl_fire});
            fetch_busy = 1'b0;
            tbl_rdata  = rows[i].rd;
            #1 chk("fire", 64'h1, tbl_fire);
            @(negedge ref_clk);
            chk("done", 64'h0, {tbl_valid, tbl_fire});
            chk("state", rows[i].pst, diag_rdata[16:15]);
        end
        miss0 = diag_rdata[3:0];
        ev(9'h100);
        ev(9'h100);
        wr(64'h0000_0000_0000_000F);
        chk("miss count", 4'(miss0 + 4'h2), diag_rdata[3:0]);
        ev(9'h0C0);
        chk("link wrote", 64'h2, diag_rdata[12:9]);
        ev(9'h030);
        chk("ret hit", 64'h6, diag_rdata[12:9]);
        ev(9'h080);
        chk("link no write", 64'h4, diag_rdata[12:9]);
        ev(9'h00E);
        chk("mispredict", 64'h32, {diag_rdata[12:9], diag_rdata[16:15]});
        ev(9'h009);
        chk("predicted", 64'h11, {diag_rdata[12:9], diag_rdata[16:15]});
        @(negedge ref_clk) bsel_in = 4'hA;
        rc_valid_in = 1'b1;
        @(negedge ref_clk);
        chk("levels", 64'hAA, diag_rdata[12:4]);
        fetch_busy = 1'b1;
        tbl_rdata  = 2'h3;
        @(negedge ref_clk) mt_en = 1'b1;
        mt_data = 64'h0000_0000_0423_0000;
        @(negedge ref_clk) mt_data = 64'h0000_0000_01E0_0000;
        @(negedge ref_clk) mt_en = 1'b0;
        fetch_busy = 1'b0;
        #1 chk("replaced", {1'b1, 2'h0, 9'h0F0}, {tbl_fire, tbl_cmd[12:2]});
        @(negedge ref_clk);
        chk("single launch", 64'h3, {tbl_valid, tbl_fire, diag_rdata[16:15]});
        wr(64'h0000_0000_0000_4100);
        @(negedge ref_clk) rst = 1'b1;
        @(negedge ref_clk) rst = 1'b0;
        chk("mid reset", 64'h0, {diag_rdata[DIAG_W-1:INSTRUCTION_XLATE_BUFFER_W], tbl_valid});
        chk("mid mode", BPD_ALG_COUNTER, predict_algorithm_sel);
        stop_test();
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        errors++;
        stop_test();
    end
endmodule
